// >>> rtl/tsdr_bank.sv
// tile status and debug register bank on the processor-status port
`timescale 1ns/10ps
module tsdr_bank
   import tsdr_pkg::*;
#(
   parameter int CNT_W = TSDR_OSC_CNT_W
)(
   input  wire logic                        clk,              // tile clock, 250 MHz
   input  wire logic                        reset,            // async, active high
   // processor-status port
   input  wire logic                        ps_rd,            // status read strobe
   input  wire logic                        ps_wr,            // status write strobe
   input  wire logic [7:0]                  ps_reg,           // register number
   input  wire logic [31:0]                 ps_wdata,         // write data
   output logic      [31:0]                 ps_rdata,         // read data
   output logic                             ps_rvalid,        // read data valid pulse
   input  wire logic                        debug_mode,       // core is in debug mode
   // boot and security
   input  wire logic [7:0]                  tile_number,      // switch tile number
   input  wire logic                        otp_boot_en,      // OTP boot enabled
   input  wire logic [TSDR_BOOT_PINS_W-1:0] boot_select_pin,  // raw boot-select pins
   input  wire logic [31:0]                 security_word,    // word loaded from OTP
   // ring oscillators
   input  wire logic [TSDR_OSC_N-1:0]       osc_ring,         // raw oscillator outputs
   output logic                             tile_osc_run,     // run tile oscillators
   output logic                             periph_osc_run,   // run peripheral oscillators
   // debug entry
   input  wire logic                        debug_enter,      // debugger entry pulse
   input  wire logic [31:0]                 saved_status_value,    // saved status
   input  wire logic [31:0]                 saved_program_counter, // saved PC
   input  wire logic [31:0]                 saved_stack_pointer,   // saved SP
   input  wire logic [2:0]                  entry_cause,      // cause code
   input  wire logic [TSDR_BP_N-1:0]        bp_hit,           // firing break/watchpoints
   input  wire logic                        core_caused,      // a core raised it
   input  wire logic [7:0]                  entry_core,       // that core's number
   // operands of the debug core register read
   output logic      [TSDR_CORE_SEL_W-1:0]  inspect_core,     // selected core
   output logic      [TSDR_REG_SEL_W-1:0]   inspect_reg       // selected register
);

   generate
      if (CNT_W < 1 || CNT_W > TSDR_OSC_CNT_W) begin : g_bad_width
         $error("counter width outside 1..16");
      end
   endgenerate

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      logic [TSDR_BOOT_PINS_W-1:0] pin_sync1;
      logic [TSDR_BOOT_PINS_W-1:0] pin_sync2;
      logic [1:0]                  osc_run;
      logic [31:0]                 saved_status;
      logic [31:0]                 saved_pc;
      logic [31:0]                 saved_stack;
      logic [TSDR_CORE_SEL_W-1:0]  core_sel;
      logic [TSDR_REG_SEL_W-1:0]   reg_sel;
      logic [1:0]                  cause_idx;
      logic [7:0]                  cause_core;
      logic [2:0]                  cause_code;
      logic [31:0]                 rdata;
      logic                        rvalid;
   } tsdr_state_t;

   localparam tsdr_state_t STATE_RST = '{
      pin_sync1    : '0,
      pin_sync2    : '0,
      osc_run      : TSDR_OSC_RUN_RST,
      saved_status : TSDR_WORD_RST,
      saved_pc     : TSDR_WORD_RST,
      saved_stack  : TSDR_WORD_RST,
      core_sel     : '0,
      reg_sel      : '0,
      cause_idx    : '0,
      cause_core   : '0,
      cause_code   : TSDR_CAUSE_NONE,
      rdata        : TSDR_WORD_RST,
      rvalid       : 1'b0
   };

   tsdr_state_t s_q;
   tsdr_state_t s_d;

   tsdr_osc_if osc ();

   // ----------------------------------------------------------
   // oscillator counters
   // ----------------------------------------------------------
   tsdr_osc_count #(
      .CNT_W    (CNT_W)
   ) u_osc_count (
      .clk      (clk),
      .osc_ring (osc_ring),
      .osc      (osc.cnt)
   );

   // channels 0,1 are tile cell/wire, 2,3 peripheral cell/wire
   assign osc.run = {{2{s_q.osc_run[TSDR_RUN_PERIPH_BIT]}},
                     {2{s_q.osc_run[TSDR_RUN_TILE_BIT]}}};

   // ----------------------------------------------------------
   // lowest firing break/watchpoint index
   // ----------------------------------------------------------
   function automatic logic [1:0] lowest_hit(input logic [TSDR_BP_N-1:0] hits);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = TSDR_BP_N - 1; i >= 0; i--) begin
         if (hits[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // ----------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [7:0] num, input tsdr_state_t s,
                                             input logic [TSDR_OSC_N-1:0][TSDR_OSC_CNT_W-1:0] cnt);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (num)
         TSDR_REG_BOOT_INFO: begin
            w[TSDR_BOOT_TILE_LSB +: 8]          = tile_number;
            w[TSDR_BOOT_OTP_BIT]                = otp_boot_en;
            w[TSDR_BOOT_PINS_W-1:0]             = s.pin_sync2;
         end
         TSDR_REG_SECURITY: begin
            w = security_word;
         end
         TSDR_REG_OSC_RUN: begin
            w[1:0] = s.osc_run;
         end
         TSDR_REG_SAVED_STATUS: begin
            w = s.saved_status;
         end
         TSDR_REG_SAVED_PC: begin
            w = s.saved_pc;
         end
         TSDR_REG_SAVED_STACK: begin
            w = s.saved_stack;
         end
         TSDR_REG_CORE_SELECT: begin
            w[TSDR_CORE_SEL_W-1:0] = s.core_sel;
         end
         TSDR_REG_REG_SELECT: begin
            w[TSDR_REG_SEL_W-1:0] = s.reg_sel;
         end
         TSDR_REG_ENTRY_CAUSE: begin
            w[TSDR_CAUSE_IDX_LSB +: 2]  = s.cause_idx;
            w[TSDR_CAUSE_CORE_LSB +: 8] = s.cause_core;
            w[2:0]                      = s.cause_code;
         end
         default: begin
            // counts sit at four consecutive numbers
            if (num >= TSDR_REG_OSC_COUNT0 && num <= TSDR_REG_OSC_COUNT3) begin
               w[TSDR_OSC_CNT_W-1:0] = cnt[2'(num - TSDR_REG_OSC_COUNT0)];
            end
         end
      endcase
      return w;
   endfunction

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb begin
      logic dbg_wr;
      dbg_wr = ps_wr && debug_mode;
      s_d    = s_q;

      // boot-select pins come from outside the clock domain
      s_d.pin_sync1 = boot_select_pin;
      s_d.pin_sync2 = s_q.pin_sync1;

      // read answers one cycle after the strobe
      s_d.rvalid = ps_rd;
      if (ps_rd) begin
         s_d.rdata = read_word(ps_reg, s_q, osc.count);
      end

      // plain writes; debug-only registers need debug mode
      if (ps_wr && ps_reg == TSDR_REG_OSC_RUN) begin
         s_d.osc_run = ps_wdata[1:0];
      end
      if (dbg_wr) begin
         unique case (ps_reg)
            TSDR_REG_SAVED_PC: begin
               s_d.saved_pc = ps_wdata;
            end
            TSDR_REG_SAVED_STACK: begin
               s_d.saved_stack = ps_wdata;
            end
            TSDR_REG_CORE_SELECT: begin
               s_d.core_sel = ps_wdata[TSDR_CORE_SEL_W-1:0];
            end
            TSDR_REG_REG_SELECT: begin
               s_d.reg_sel = ps_wdata[TSDR_REG_SEL_W-1:0];
            end
            TSDR_REG_ENTRY_CAUSE: begin
               s_d.cause_idx  = ps_wdata[TSDR_CAUSE_IDX_LSB +: 2];
               s_d.cause_core = ps_wdata[TSDR_CAUSE_CORE_LSB +: 8];
               s_d.cause_code = ps_wdata[2:0];
            end
            default: begin
               // read-only and unmapped numbers ignore writes
               s_d.rvalid = s_d.rvalid;
            end
         endcase
      end

      // capture after writes so a same-cycle entry always wins
      if (debug_enter) begin
         s_d.saved_status = saved_status_value;
         s_d.saved_pc     = saved_program_counter;
         s_d.saved_stack  = saved_stack_pointer;
         s_d.cause_code = entry_cause;
         s_d.cause_idx  = 2'h0;
         if (entry_cause == TSDR_CAUSE_INSN_BP || entry_cause == TSDR_CAUSE_DATA_WP
             || entry_cause == TSDR_CAUSE_RES_WP) begin
            s_d.cause_idx = lowest_hit(bp_hit);
         end
         s_d.cause_core = core_caused ? entry_core : 8'h00;
      end
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------
   // outputs, all straight from flip-flops
   // ----------------------------------------------------------
   assign ps_rdata       = s_q.rdata;
   assign ps_rvalid      = s_q.rvalid;
   assign tile_osc_run   = s_q.osc_run[TSDR_RUN_TILE_BIT];
   assign periph_osc_run = s_q.osc_run[TSDR_RUN_PERIPH_BIT];
   assign inspect_core   = s_q.core_sel;
   assign inspect_reg    = s_q.reg_sel;

   // counts drift while oscillators run; stop them before reading

endmodule

// >>> rtl/tsdr_osc_count.sv
// ring oscillator edge counters, one per oscillator
`timescale 1ns/10ps
module tsdr_osc_count
   import tsdr_pkg::*;
#(
   parameter int CNT_W = TSDR_OSC_CNT_W
)(
   input  wire logic                  clk,      // tile clock
   input  wire logic [TSDR_OSC_N-1:0] osc_ring, // raw ring oscillator outputs
   tsdr_osc_if.cnt                    osc       // run in, counts out
);

   generate
      if (CNT_W < 1 || CNT_W > TSDR_OSC_CNT_W) begin : g_bad_width
         $error("counter width outside 1..16");
      end
   endgenerate

   typedef struct packed {
      logic [TSDR_OSC_N-1:0]            sync1;
      logic [TSDR_OSC_N-1:0]            sync2;
      logic [TSDR_OSC_N-1:0]            last;
      logic [TSDR_OSC_N-1:0][CNT_W-1:0] cnt;
   } tsdr_cnt_state_t;

   // power-on value only; a system reset never clears the counts
   tsdr_cnt_state_t s_q = '0;
   tsdr_cnt_state_t s_d;

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = osc_ring;
      s_d.sync2 = s_q.sync1;
      s_d.last  = s_q.sync2;
      for (int i = 0; i < TSDR_OSC_N; i++) begin
         // count rising edges only while this oscillator runs
         if (osc.run[i] && s_q.sync2[i] && !s_q.last[i]) begin
            s_d.cnt[i] = s_q.cnt[i] + CNT_W'(1);
         end
      end
   end

   // no reset on purpose: counts must outlive a system reset
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   generate
      for (genvar g = 0; g < TSDR_OSC_N; g++) begin : g_out
         assign osc.count[g] = TSDR_OSC_CNT_W'(s_q.cnt[g]);
      end
   endgenerate

endmodule

// >>> rtl/tsdr_osc_if.sv
// carrier between register bank and oscillator counters
`timescale 1ns/10ps
interface tsdr_osc_if;
   import tsdr_pkg::*;
   logic [TSDR_OSC_N-1:0]                     run;
   logic [TSDR_OSC_N-1:0][TSDR_OSC_CNT_W-1:0] count;
   modport ctrl (output run, input count);
   modport cnt  (input run, output count);
endinterface

// >>> rtl/tsdr_pkg.sv
// constants and types of the tile status and debug register bank
//
// Functional notes
// - boot status bits 23:16 give tile number
// - boot status bit 8 flags OTP boot
// - boot status bits 7:0 show boot-select pins
// - security register is read-only loaded word image
// - four ring oscillators each clock own counter
// - control bit1 runs tile, bit0 peripheral oscillators
// - four count registers, bits 15:0, fixed order
// - oscillator counts survive system reset
// - oscillators asynchronous, synchronised into tile clock
// - debugger entry captures saved status value
// - debugger entry captures program counter, debugger-writable
// - debugger entry captures stack pointer, debugger-writable
// - operand one bits 7:0 select core
// - operand two bits 4:0 select register
// - cause bits 2:0 encode debug source
// - bits 17:16 hold lowest firing breakpoint index
// - bits 15:8 hold causing core, else zero
// - reached by processor-status reads and writes
package tsdr_pkg;

   // ----------------------------------------------------------
   // register numbers
   // ----------------------------------------------------------
   localparam logic [7:0] TSDR_REG_BOOT_INFO     = 8'h03;
   localparam logic [7:0] TSDR_REG_SECURITY      = 8'h05;
   localparam logic [7:0] TSDR_REG_OSC_RUN       = 8'h06;
   localparam logic [7:0] TSDR_REG_OSC_COUNT0    = 8'h07;
   localparam logic [7:0] TSDR_REG_OSC_COUNT3    = 8'h0a;
   localparam logic [7:0] TSDR_REG_SAVED_STATUS  = 8'h10;
   localparam logic [7:0] TSDR_REG_SAVED_PC      = 8'h11;
   localparam logic [7:0] TSDR_REG_SAVED_STACK   = 8'h12;
   localparam logic [7:0] TSDR_REG_CORE_SELECT   = 8'h13;
   localparam logic [7:0] TSDR_REG_REG_SELECT    = 8'h14;
   localparam logic [7:0] TSDR_REG_ENTRY_CAUSE   = 8'h15;

   // ----------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------
   localparam int TSDR_BOOT_TILE_LSB   = 16;
   localparam int TSDR_BOOT_OTP_BIT    = 8;
   localparam int TSDR_BOOT_PINS_W     = 8;
   localparam int TSDR_RUN_TILE_BIT    = 1;
   localparam int TSDR_RUN_PERIPH_BIT  = 0;
   localparam int TSDR_OSC_N           = 4;
   localparam int TSDR_OSC_CNT_W       = 16;
   localparam int TSDR_CORE_SEL_W      = 8;
   localparam int TSDR_REG_SEL_W       = 5;
   localparam int TSDR_CAUSE_IDX_LSB   = 16;
   localparam int TSDR_CAUSE_CORE_LSB  = 8;
   localparam int TSDR_BP_N            = 4;

   // ----------------------------------------------------------
   // reset values
   // ----------------------------------------------------------
   localparam logic [1:0]  TSDR_OSC_RUN_RST = 2'h0;
   localparam logic [31:0] TSDR_WORD_RST    = 32'h0000_0000;

   // ----------------------------------------------------------
   // debug entry causes
   // ----------------------------------------------------------
   typedef enum logic [2:0] {
      TSDR_CAUSE_NONE     = 3'h0,
      TSDR_CAUSE_JTAG     = 3'h1,
      TSDR_CAUSE_CALL     = 3'h2,
      TSDR_CAUSE_INSN_BP  = 3'h3,
      TSDR_CAUSE_DATA_WP  = 3'h4,
      TSDR_CAUSE_RES_WP   = 3'h5
   } tsdr_cause_t;

endpackage

// >>> verif/test_tsdr_bank.sv
// self-checking bench for the tile status and debug register bank
`timescale 1ns/10ps
module test_tsdr_bank;
   import tsdr_pkg::*;
   typedef struct {logic wr; logic dm; logic [7:0] r; logic [31:0] wd; logic [31:0] ex;} tsdr_row_t;

   logic        clk, reset, ps_rd, ps_wr, ps_rvalid, debug_mode, debug_enter, core_caused;
   logic        tile_osc_run, periph_osc_run;
   logic [7:0]  ps_reg, entry_core, inspect_core;
   logic [31:0] ps_wdata, ps_rdata, sv_status, sv_pc, sv_sp, v;
   logic [3:0]  osc_ring, bp_hit;
   logic [2:0]  entry_cause;
   logic [4:0]  inspect_reg;
   logic [15:0] base [4];
   int          error_cnt = 0;
   int          n_compared = 0;

   tsdr_row_t rows [14] = '{
      '{1, 1, 8'h03, 32'hffff_ffff, 32'h005a_0196},
      '{1, 1, 8'h05, 32'h0000_0000, 32'hc3a5_5a3c},
      '{1, 0, 8'h06, 32'hffff_ffff, 32'h0000_0003},
      '{1, 0, 8'h06, 32'h0000_0001, 32'h0000_0001},
      '{1, 1, 8'h13, 32'hffff_ffff, 32'h0000_00ff},
      '{1, 1, 8'h14, 32'hffff_ffff, 32'h0000_001f},
      '{1, 1, 8'h11, 32'h1234_5678, 32'h1234_5678},
      '{1, 1, 8'h12, 32'h8765_4321, 32'h8765_4321},
      '{1, 1, 8'h15, 32'hffff_ffff, 32'h0003_ff07},
      '{1, 0, 8'h15, 32'h0000_0000, 32'h0003_ff07},
      '{1, 1, 8'h10, 32'hffff_ffff, 32'h0000_0000},
      '{1, 1, 8'h04, 32'hffff_ffff, 32'h0000_0000},
      '{0, 1, 8'h16, 32'h0000_0000, 32'h0000_0000},
      '{1, 0, 8'h06, 32'h0000_0000, 32'h0000_0000}};

   tsdr_core_model i_tsdr_core_model (.clk(clk), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .ps_rd(ps_rd),
      .ps_wr(ps_wr), .ps_reg(ps_reg), .ps_wdata(ps_wdata), .debug_mode(debug_mode));

   tsdr_bank i_tsdr_bank (.clk(clk), .reset(reset), .ps_rd(ps_rd), .ps_wr(ps_wr), .ps_reg(ps_reg),
      .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .debug_mode(debug_mode),
      .tile_number(8'h5a), .otp_boot_en(1'b1), .boot_select_pin(8'h96), .security_word(32'hc3a5_5a3c),
      .osc_ring(osc_ring), .tile_osc_run(tile_osc_run), .periph_osc_run(periph_osc_run),
      .debug_enter(debug_enter), .saved_status_value(sv_status), .saved_program_counter(sv_pc),
      .saved_stack_pointer(sv_sp), .entry_cause(entry_cause), .bp_hit(bp_hit), .core_caused(core_caused),
      .entry_core(entry_core), .inspect_core(inspect_core), .inspect_reg(inspect_reg));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic rc(input logic [7:0] r, input logic [31:0] ex);
      logic [31:0] got;
      i_tsdr_core_model.ps_read(r, got);
      chk($sformatf("reg %h", r), ex, got);
   endtask

   // slow enough that every edge survives the two-flop synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         #20 osc_ring = 4'hf;
         #20 osc_ring = 4'h0;
      end
      repeat (8) @(negedge clk);
   endtask

   task automatic wrap_up;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      wrap_up();
   end

   initial begin
      reset = 1'b1;
      {debug_enter, core_caused, entry_core, entry_cause, bp_hit, osc_ring} = '0;
      {sv_status, sv_pc, sv_sp} = '0;
      repeat (8) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      chk("run outputs", 32'h0, {30'h0, tile_osc_run, periph_osc_run});
      chk("inspect core", 32'h0, {24'h0, inspect_core});
      rc(TSDR_REG_ENTRY_CAUSE, 32'h0);
      foreach (rows[i]) begin
         if (rows[i].wr) i_tsdr_core_model.ps_write(rows[i].r, rows[i].wd, rows[i].dm);
         rc(rows[i].r, rows[i].ex);
      end
      chk("inspect core", 32'hff, {24'h0, inspect_core});
      chk("inspect reg", 32'h1f, {27'h0, inspect_reg});
      chk("run outputs", 32'h0, {30'h0, tile_osc_run, periph_osc_run});
      for (int c = 1; c <= 5; c++) begin
         @(negedge clk);
         {entry_cause, bp_hit, core_caused, entry_core} = {c[2:0], 4'b1100, c[0], 8'h20 + c[7:0]};
         {sv_status, sv_pc, sv_sp} = {{4{c[7:0]}}, 32'h1000_0000 + c, 32'hefff_ff00 - c};
         debug_enter = 1'b1;
         @(negedge clk) debug_enter = 1'b0;
         rc(TSDR_REG_ENTRY_CAUSE, {14'h0, c >= 3 ? 2'd2 : 2'd0, c[0] ? 8'h20 + c[7:0] : 8'h00, 5'h0, c[2:0]});
         rc(TSDR_REG_SAVED_STATUS, {4{c[7:0]}});
         rc(TSDR_REG_SAVED_PC, 32'h1000_0000 + c);
         rc(TSDR_REG_SAVED_STACK, 32'hefff_ff00 - c);
      end
      for (int i = 0; i < 4; i++) begin
         i_tsdr_core_model.ps_read(TSDR_REG_OSC_COUNT0 + i[7:0], v);
         base[i] = v[15:0];
      end
      i_tsdr_core_model.ps_write(TSDR_REG_OSC_RUN, 32'h3, 1'b0);
      pulses(5);
      i_tsdr_core_model.ps_write(TSDR_REG_OSC_RUN, 32'h2, 1'b0);
      pulses(3);
      i_tsdr_core_model.ps_write(TSDR_REG_OSC_RUN, 32'h0, 1'b0);
      pulses(2);
      @(negedge clk) reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 4; i++) rc(TSDR_REG_OSC_COUNT0 + i[7:0], {16'h0, base[i] + (i < 2 ? 16'd8 : 16'd5)});
      rc(TSDR_REG_SAVED_PC, 32'h0);
      wrap_up();
   end
endmodule

// >>> verif/tsdr_bank_properties.sv
// concurrent checks on the ports of the tile status and debug register bank
`timescale 1ns/10ps
module tsdr_bank_properties
   import tsdr_pkg::*;
#(
   parameter int CNT_W = TSDR_OSC_CNT_W
)(
   input wire logic                       clk,            // tile clock
   input wire logic                       reset,          // async, active high
   input wire logic                       ps_rd,          // read strobe
   input wire logic                       ps_wr,          // write strobe
   input wire logic [7:0]                 ps_reg,         // register number
   input wire logic [31:0]                ps_wdata,       // write data
   input wire logic [31:0]                ps_rdata,       // read data
   input wire logic                       ps_rvalid,      // read data valid
   input wire logic                       debug_mode,     // debug mode level
   input wire logic                       tile_osc_run,   // tile oscillators run
   input wire logic                       periph_osc_run, // peripheral oscillators run
   input wire logic [TSDR_CORE_SEL_W-1:0] inspect_core,   // selected core
   input wire logic [TSDR_REG_SEL_W-1:0]  inspect_reg     // selected register
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_rvalid_follows_read: assert property (ps_rd |=> ps_rvalid)
      else $error("read not answered in the next cycle");
   a_rvalid_needs_read: assert property (ps_rvalid |-> $past(ps_rd))
      else $error("read valid without a read");
   a_rdata_stands: assert property (!ps_rd |=> $stable(ps_rdata))
      else $error("read data moved without a read");
   a_run_follows_write: assert property (ps_wr && ps_reg == TSDR_REG_OSC_RUN |=>
      {tile_osc_run, periph_osc_run} == $past(ps_wdata[1:0]))
      else $error("oscillator run outputs differ from written bits");
   a_run_holds: assert property (!(ps_wr && ps_reg == TSDR_REG_OSC_RUN) |=>
      $stable({tile_osc_run, periph_osc_run}))
      else $error("oscillator run outputs changed without a write");
   a_core_sel_write: assert property (ps_wr && debug_mode && ps_reg == TSDR_REG_CORE_SELECT |=>
      inspect_core == $past(ps_wdata[7:0]))
      else $error("core select not taken from write");
   a_core_sel_holds: assert property (!(ps_wr && debug_mode && ps_reg == TSDR_REG_CORE_SELECT) |=>
      $stable(inspect_core))
      else $error("core select changed without a debug write");
   a_reg_sel_write: assert property (ps_wr && debug_mode && ps_reg == TSDR_REG_REG_SELECT |=>
      inspect_reg == $past(ps_wdata[4:0]))
      else $error("register select not taken from write");
   a_boot_reserved_zero: assert property (ps_rd && ps_reg == TSDR_REG_BOOT_INFO |=>
      ps_rdata[31:24] == 8'h00 && ps_rdata[15:9] == 7'h00)
      else $error("boot status reserved bits not zero");
   a_count_upper_zero: assert property (ps_rd && ps_reg inside {[TSDR_REG_OSC_COUNT0:TSDR_REG_OSC_COUNT3]} |=>
      ps_rdata[31:CNT_W] == '0)
      else $error("count upper bits not zero");
   a_cause_reserved_zero: assert property (ps_rd && ps_reg == TSDR_REG_ENTRY_CAUSE |=>
      ps_rdata[31:18] == 14'h0000 && ps_rdata[7:3] == 5'h00)
      else $error("cause reserved bits not zero");

   c_run_write: cover property (ps_wr && ps_reg == TSDR_REG_OSC_RUN);
   c_refused_write: cover property (ps_wr && !debug_mode && ps_reg == TSDR_REG_ENTRY_CAUSE);
   c_count_read: cover property (ps_rd && ps_reg == TSDR_REG_OSC_COUNT3);
endmodule

bind tsdr_bank tsdr_bank_properties #(.CNT_W(CNT_W)) i_tsdr_bank_properties (
   .clk(clk), .reset(reset), .ps_rd(ps_rd), .ps_wr(ps_wr), .ps_reg(ps_reg),
   .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .debug_mode(debug_mode),
   .tile_osc_run(tile_osc_run), .periph_osc_run(periph_osc_run),
   .inspect_core(inspect_core), .inspect_reg(inspect_reg)
);

// >>> verif/tsdr_core_model.sv
// processor core model issuing processor-status reads and writes
`timescale 1ns/10ps
module tsdr_core_model (
   input  wire logic        clk,        // tile clock
   input  wire logic [31:0] ps_rdata,   // read data
   input  wire logic        ps_rvalid,  // read data valid
   output logic             ps_rd,      // read strobe
   output logic             ps_wr,      // write strobe
   output logic      [7:0]  ps_reg,     // register number
   output logic      [31:0] ps_wdata,   // write data
   output logic             debug_mode  // debug mode level
);
   initial begin
      ps_rd = 1'b0;
      ps_wr = 1'b0;
      ps_reg = 8'h00;
      ps_wdata = 32'h0000_0000;
      debug_mode = 1'b0;
   end

   // one-cycle strobe, then address and data flipped so stale values never match
   task automatic ps_write(input logic [7:0] r, input logic [31:0] wd, input logic dm);
      @(negedge clk);
      ps_wr = 1'b1;
      ps_reg = r;
      ps_wdata = wd;
      debug_mode = dm;
      @(negedge clk);
      ps_wr = 1'b0;
      ps_reg = ~r;
      ps_wdata = ~wd;
   endtask

   task automatic ps_read(input logic [7:0] r, output logic [31:0] rd);
      @(negedge clk);
      ps_rd = 1'b1;
      ps_reg = r;
      @(negedge clk);
      ps_rd = 1'b0;
      ps_reg = ~r;
      rd = (ps_rvalid === 1'b1) ? ps_rdata : 'x;
   endtask
endmodule
